// ===== pms_host_model.sv
// host processor model: register strobes and control pins
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic en,
  output logic req
);
  // idle pins at time zero
  initial begin
    wr = 1'h0;
    rd = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    en = 1'h0;
    req = 1'h0;
  end
  // one write strobe, dropped after the taking edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
    wdata <= ~d;
  endtask : write
  // read strobe, data picked up the cycle after
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    d = rdata;
  endtask : read
  // enable pin level, high asks for turn-on
  task automatic set_en(input logic v);
    @(posedge clk);
    en <= v;
  endtask : set_en
  // raw low-power request pin
  task automatic set_req(input logic v);
    @(posedge clk);
    req <= v;
  endtask : set_req
  // polarity goes in before any standby setting
  task automatic lowpower_setup(input logic [7:0] ctrl, input logic [7:0] stby0);
    write(`PMS_ADDR_PWR_CTRL, ctrl);
    write(`PMS_ADDR_LOW_POWER_REQUEST_BASE, stby0);
  endtask : lowpower_setup
endmodule : pms_host_model

// ===== pms_pkg.sv
// shared types of the power mode and start-up sequencer
`include "pms_regs.svh"
package pms_pkg;
  typedef enum logic [1:0] {PMS_OFF, PMS_ON, PMS_SLEEP, PMS_STANDBY} pms_state_e;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SLOT, SEQ_PGOOD, SEQ_DONE} pms_seq_e;
  typedef logic [`PMS_SLOT_W-1:0] pms_slot_t;
  typedef logic [`PMS_NUM_REGS-1:0][`PMS_SLOT_W-1:0] pms_slot_vec_t;
  typedef logic [`PMS_NUM_REGS-1:0] pms_mask_t;
endpackage : pms_pkg

// ===== pms_power_sequencer.sv
// power mode state machine, start-up slot sequencer and control registers
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_power_sequencer #(
  parameter int unsigned SLOT_CYC = `PMS_SLOT_PERIOD_NS / `PMS_CLK_PERIOD_NS,
  parameter int unsigned FIRST_CYC = `PMS_FIRST_SLOT_NS / `PMS_CLK_PERIOD_NS,
  parameter int unsigned PGOOD_CYC = `PMS_PGOOD_DELAY_NS / `PMS_CLK_PERIOD_NS
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic MAIN_SUPPLY_OK,
  input wire logic EN_PIN,
  input wire logic THERMAL_SHDN,
  input wire logic LOW_POWER_REQUEST,
  input wire logic ANY_OFF_MODE_PFM,
  input wire logic ALL_PFM,
  input wire logic UNTRIMMED_TICK,
  input wire logic FAULT_PENDING,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic HOST_CTRL_READY,
  output logic [`PMS_NUM_REGS-1:0] REG_ENABLE,
  output logic POWER_GOOD_RESET_N_O,
  output logic POWER_GOOD_RESET_N_OE,
  output logic FAULT_IRQ_N_O,
  output logic FAULT_IRQ_N_OE,
  output logic DDR_REF_OUTPUT_ON,
  output logic CLK_UNTRIMMED_SEL,
  output logic SWITCH_CLK_TICK,
  output logic DEBOUNCE_TICK,
  output logic IRQ_DEBOUNCE_TICK,
  output logic [6:0] I2C_ADDR,
  output logic [1:0] POWER_STATE
);
  localparam int N = `PMS_NUM_REGS;
  localparam pms_pkg::pms_slot_vec_t DEF_SLOTS = `PMS_DEF_SLOTS;

  // lowest slot above cur, zero when none remain
  function automatic pms_pkg::pms_slot_t next_slot(input pms_pkg::pms_slot_vec_t s,
                                                    input pms_pkg::pms_slot_t cur);
    pms_pkg::pms_slot_t best;
    best = '0;
    for (int i = 0; i < N; i++) begin
      if (s[i] > cur && (best == '0 || s[i] < best)) begin
        best = s[i];
      end
    end
    return best;
  endfunction : next_slot

  // regulators placed in slot cur
  function automatic pms_pkg::pms_mask_t slot_mask(input pms_pkg::pms_slot_vec_t s,
                                                   input pms_pkg::pms_slot_t cur);
    pms_pkg::pms_mask_t m;
    m = '0;
    for (int i = 0; i < N; i++) begin
      m[i] = (s[i] == cur);
    end
    return m;
  endfunction : slot_mask

  // address decode of one per-regulator register
  function automatic logic slot_hit(input logic [7:0] addr, input logic [7:0] base,
                                    input int idx);
    return addr == 8'(base + 8'(idx));
  endfunction : slot_hit

  pms_tick_if tk ();
  pms_pkg::pms_state_e state;
  pms_pkg::pms_state_e next_state;
  pms_pkg::pms_seq_e seq;
  pms_pkg::pms_slot_vec_t ram_slot;
  pms_pkg::pms_slot_vec_t act_slot;
  pms_pkg::pms_slot_vec_t low_power_request_slot;
  pms_pkg::pms_slot_t cur;
  pms_pkg::pms_mask_t en_mask;
  logic [31:0] seq_timer;
  logic [1:0] lp_delay;
  logic [1:0] dly_cnt;
  logic [`PMS_SYNC_STAGES-1:0] req_sync;
  logic invert;
  logic ref_on;
  logic ram_sel;
  logic first_done;
  logic pg_released;
  logic debounce_tick;
  logic irq_tick;
  logic [7:0] rdata;

  // turn-on qualification and sequencer status
  wire supply_ok = MAIN_SUPPLY_OK;
  wire turn_on = EN_PIN && supply_ok && !THERMAL_SHDN;
  wire force_off = THERMAL_SHDN || !supply_ok;
  wire seq_start = (state == pms_pkg::PMS_OFF) && (next_state == pms_pkg::PMS_ON);
  wire seq_busy = (seq != pms_pkg::SEQ_IDLE) && (seq != pms_pkg::SEQ_DONE);
  wire wr_ok = REG_WR && !seq_busy;
  wire req_decoded = LOW_POWER_REQUEST ^ invert;
  wire req_qual = req_sync[`PMS_SYNC_STAGES-1];
  wire lf_tick = tk.tick_32k;
  wire low_power_request_go = req_qual && (dly_cnt == lp_delay) && (seq == pms_pkg::SEQ_DONE);
  wire untrimmed_sel = !supply_ok || (!seq_busy && (state == pms_pkg::PMS_SLEEP || ALL_PFM));
  wire pms_pkg::pms_slot_t nxt = next_slot(act_slot, cur);
  wire pms_pkg::pms_slot_t first = next_slot(act_slot, '0);
  wire pms_pkg::pms_mask_t low_power_request_mask = ~slot_mask(low_power_request_slot, '0);

  pms_tick_gen u_tick (
    .clk(CORE_CLK),
    .rst(RST),
    .osc_on(!untrimmed_sel),
    .tk(tk)
  );

  // power state transitions
  always_comb begin
    next_state = state;
    case (state)
      pms_pkg::PMS_OFF: begin
        if (turn_on) next_state = pms_pkg::PMS_ON;
      end
      pms_pkg::PMS_SLEEP: begin
        if (force_off) next_state = pms_pkg::PMS_OFF;
        else if (turn_on) next_state = pms_pkg::PMS_ON;
      end
      pms_pkg::PMS_ON: begin
        if (force_off) next_state = pms_pkg::PMS_OFF;
        else if (!EN_PIN) next_state = ANY_OFF_MODE_PFM ? pms_pkg::PMS_SLEEP : pms_pkg::PMS_OFF;
        else if (low_power_request_go) next_state = pms_pkg::PMS_STANDBY;
      end
      pms_pkg::PMS_STANDBY: begin
        if (force_off) next_state = pms_pkg::PMS_OFF;
        else if (!EN_PIN) next_state = ANY_OFF_MODE_PFM ? pms_pkg::PMS_SLEEP : pms_pkg::PMS_OFF;
        else if (!req_qual) next_state = pms_pkg::PMS_ON;
      end
      default: next_state = pms_pkg::PMS_OFF;
    endcase
  end

  // state register, OFF after supply-valid reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) state <= pms_pkg::PMS_OFF;
    else state <= next_state;
  end

  // control bits written by the host
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      invert <= `PMS_RST_INVERT;
      lp_delay <= `PMS_RST_DELAY;
      ref_on <= `PMS_RST_REF_ON;
      ram_sel <= `PMS_RST_RAM_SEL;
    end else if (wr_ok) begin
      if (REG_ADDR == `PMS_ADDR_PWR_CTRL) begin
        invert <= REG_WDATA[`PMS_BIT_INVERT];
        lp_delay <= REG_WDATA[`PMS_DLY_MSB:`PMS_DLY_LSB];
      end
      if (REG_ADDR == `PMS_ADDR_DDR_REF) ref_on <= REG_WDATA[`PMS_BIT_REF_ON];
      if (REG_ADDR == `PMS_ADDR_RAM_SEL) ram_sel <= REG_WDATA[`PMS_BIT_RAM_SEL];
    end
  end

  // per-regulator retained, active and standby slot fields
  for (genvar g = 0; g < N; g++) begin : g_reg
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        ram_slot[g] <= '0;
        low_power_request_slot[g] <= '0;
        act_slot[g] <= '0;
      end else if (seq_start) begin
        act_slot[g] <= ram_sel ? ram_slot[g] : DEF_SLOTS[g];
        if (!first_done) low_power_request_slot[g] <= ram_sel ? ram_slot[g] : DEF_SLOTS[g];
      end else if (wr_ok) begin
        if (slot_hit(REG_ADDR, `PMS_ADDR_SLOT_BASE, g)) ram_slot[g] <= REG_WDATA[4:0];
        if (slot_hit(REG_ADDR, `PMS_ADDR_LOW_POWER_REQUEST_BASE, g)) low_power_request_slot[g] <= REG_WDATA[4:0];
      end
    end
  end

  // start-up slot sequencer
  always_ff @(posedge CORE_CLK) begin
    if (RST || state == pms_pkg::PMS_OFF) begin
      seq <= seq_start ? pms_pkg::SEQ_FIRST : pms_pkg::SEQ_IDLE;
      seq_timer <= seq_start ? FIRST_CYC - 3 : 32'h0;
      cur <= '0;
      en_mask <= '0;
      pg_released <= 1'b0;
    end else begin
      seq_timer <= (seq_timer != 32'h0) ? seq_timer - 32'h1 : 32'h0;
      case (seq)
        pms_pkg::SEQ_FIRST: begin
          if (seq_timer == 32'h0) begin
            cur <= first;
            seq <= (first == '0) ? pms_pkg::SEQ_PGOOD : pms_pkg::SEQ_SLOT;
            seq_timer <= (first == '0) ? PGOOD_CYC - 1 : 32'h0;
          end
        end
        pms_pkg::SEQ_SLOT: begin
          if (seq_timer == 32'h0) begin
            en_mask <= en_mask | (slot_mask(act_slot, cur) & ~slot_mask(act_slot, '0));
            cur <= nxt;
            seq <= (nxt == '0) ? pms_pkg::SEQ_PGOOD : pms_pkg::SEQ_SLOT;
            seq_timer <= (nxt == '0) ? PGOOD_CYC - 1 : SLOT_CYC - 1;
          end
        end
        pms_pkg::SEQ_PGOOD: begin
          if (seq_timer == 32'h0) begin
            pg_released <= 1'b1;
            seq <= pms_pkg::SEQ_DONE;
          end
        end
        pms_pkg::SEQ_IDLE: seq <= pms_pkg::SEQ_IDLE;
        pms_pkg::SEQ_DONE: seq <= pms_pkg::SEQ_DONE;
        default: seq <= pms_pkg::SEQ_IDLE;
      endcase
    end
  end

  // first power-up marker for the standby mirror
  always_ff @(posedge CORE_CLK) begin
    if (RST) first_done <= 1'b0;
    else if (seq_start) first_done <= 1'b1;
  end

  // request synchroniser and standby entry delay on the low-rate tick
  always_ff @(posedge CORE_CLK) begin
    if (RST || (state != pms_pkg::PMS_ON && state != pms_pkg::PMS_STANDBY)) begin
      req_sync <= '0;
    end else if (lf_tick) begin
      req_sync <= {req_sync[`PMS_SYNC_STAGES-2:0], req_decoded};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST || state != pms_pkg::PMS_ON || !req_qual) dly_cnt <= 2'h0;
    else if (lf_tick && dly_cnt != lp_delay) dly_cnt <= dly_cnt + 2'h1;
  end

  // debounce reference ticks
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      debounce_tick <= 1'b0;
      irq_tick <= 1'b0;
    end else begin
      debounce_tick <= (state == pms_pkg::PMS_ON && !untrimmed_sel) ? lf_tick : UNTRIMMED_TICK;
      irq_tick <= UNTRIMMED_TICK;
    end
  end

  // register read-back
  always_comb begin
    rdata = 8'h00;
    if (REG_ADDR == `PMS_ADDR_PWR_CTRL) rdata = {1'b0, invert, lp_delay, 4'h0};
    if (REG_ADDR == `PMS_ADDR_DDR_REF) rdata = {3'h0, ref_on, 4'h0};
    if (REG_ADDR == `PMS_ADDR_RAM_SEL) rdata = {7'h00, ram_sel};
    for (int i = 0; i < N; i++) begin
      if (slot_hit(REG_ADDR, `PMS_ADDR_SLOT_BASE, i)) rdata = {3'h0, ram_slot[i]};
      if (slot_hit(REG_ADDR, `PMS_ADDR_LOW_POWER_REQUEST_BASE, i)) rdata = {3'h0, low_power_request_slot[i]};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) REG_RDATA <= 8'h00;
    else if (REG_RD) REG_RDATA <= rdata;
  end

  // pin and status outputs
  wire pg_high = pg_released && state != pms_pkg::PMS_OFF;
  assign HOST_CTRL_READY = !seq_busy;
  // every regulator is dropped in the same cycle that OFF is entered
  wire pms_pkg::pms_mask_t on_mask = (state == pms_pkg::PMS_STANDBY) ? (en_mask & low_power_request_mask) : en_mask;
  assign REG_ENABLE = (state == pms_pkg::PMS_OFF) ? '0 : on_mask;
  assign POWER_GOOD_RESET_N_O = 1'b0;
  assign POWER_GOOD_RESET_N_OE = !pg_high;
  assign FAULT_IRQ_N_O = 1'b0;
  assign FAULT_IRQ_N_OE = FAULT_PENDING && state != pms_pkg::PMS_OFF;
  assign DDR_REF_OUTPUT_ON = ref_on;
  assign CLK_UNTRIMMED_SEL = untrimmed_sel;
  assign SWITCH_CLK_TICK = tk.tick_2m;
  assign DEBOUNCE_TICK = debounce_tick;
  assign IRQ_DEBOUNCE_TICK = irq_tick;
  assign I2C_ADDR = `PMS_I2C_ADDR;
  assign POWER_STATE = state;

  // timing helpers for the checks below
  logic [31:0] since_on;
  logic [31:0] gap;
  pms_pkg::pms_mask_t en_prev;
  wire en_chg = en_mask != en_prev;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      since_on <= 32'h0;
      gap <= 32'h0;
      en_prev <= '0;
    end else begin
      since_on <= seq_start ? 32'h1 : since_on + 32'h1;
      gap <= en_chg ? 32'h1 : gap + 32'h1;
      en_prev <= en_mask;
    end
  end

  chk_first_slot: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(|en_mask) |-> since_on == FIRST_CYC) else $error("first slot timing wrong");
  chk_slot_gap: assert property (@(posedge CORE_CLK) disable iff (RST)
    en_chg && (|en_prev) && seq_busy |-> gap == SLOT_CYC) else $error("slot spacing wrong");
  chk_pgood_delay: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(pg_released) && (|en_mask) |-> gap == PGOOD_CYC) else $error("reset release late");
  chk_off_reset_low: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == pms_pkg::PMS_OFF |-> POWER_GOOD_RESET_N_OE) else $error("reset not low in OFF");
  chk_irq_off: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == pms_pkg::PMS_OFF |-> !FAULT_IRQ_N_OE) else $error("interrupt driven in OFF");
  chk_no_low_start: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == pms_pkg::PMS_OFF && !MAIN_SUPPLY_OK |=> state == pms_pkg::PMS_OFF)
    else $error("power-up below threshold");
  chk_stay_off: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == pms_pkg::PMS_OFF && !EN_PIN |=> state == pms_pkg::PMS_OFF)
    else $error("OFF left without turn-on");
  chk_ref_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_ok && REG_ADDR == `PMS_ADDR_DDR_REF |=> DDR_REF_OUTPUT_ON == $past(REG_WDATA[4]))
    else $error("reference enable not written");
  chk_sleep_no_low_power_request: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == pms_pkg::PMS_SLEEP |=> state != pms_pkg::PMS_STANDBY)
    else $error("standby entered from sleep");
  chk_low_power_request_exit: assert property (@(posedge CORE_CLK) disable iff (RST)
    state == pms_pkg::PMS_STANDBY && !req_qual && EN_PIN && !force_off
    |=> state == pms_pkg::PMS_ON) else $error("standby not left");
  chk_zero_slot_off: assert property (@(posedge CORE_CLK) disable iff (RST)
    seq_busy |-> (en_mask & slot_mask(act_slot, '0)) == '0) else $error("slot 0 enabled");
  chk_low_clock: assert property (@(posedge CORE_CLK) disable iff (RST)
    !MAIN_SUPPLY_OK |-> CLK_UNTRIMMED_SEL) else $error("trimmed clock at low supply");
endmodule : pms_power_sequencer

// ===== pms_power_sequencer_tb.sv
// self-checking bench of the power mode and start-up sequencer
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_power_sequencer_tb;
  localparam int SLOT = 20;
  localparam int FIRST = 30;
  localparam int PG = 25;
  localparam logic [9:0] DEF_EN [4] = '{10'h1E0, 10'h1E3, 10'h3EF, 10'h3FF};
  logic clk, rst, supply, therm, pfm_any, all_pfm, utick, fault, wr, rd, en, req;
  logic [7:0] addr, wdata, rdata, rd_v;
  logic [9:0] en_o;
  logic por_o, por_oe, irq_o, irq_oe, ready, ref_on, slow_sel, sw_tick, db_tick, irq_tick;
  logic [6:0] i2c;
  logic [1:0] state;
  logic [5:0] tcnt;
  int num_errors = 0;
  int checked = 0;
  int n;
  int m;
  // open-drain pins with pull-ups
  wire por_n = por_oe ? por_o : 1'h1;
  wire irq_n = irq_oe ? irq_o : 1'h1;
  pms_power_sequencer #(.SLOT_CYC(SLOT), .FIRST_CYC(FIRST), .PGOOD_CYC(PG)) pms_power_sequencer_i (
    .CORE_CLK(clk), .RST(rst), .MAIN_SUPPLY_OK(supply), .EN_PIN(en), .THERMAL_SHDN(therm),
    .LOW_POWER_REQUEST(req), .ANY_OFF_MODE_PFM(pfm_any), .ALL_PFM(all_pfm),
    .UNTRIMMED_TICK(utick), .FAULT_PENDING(fault), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .HOST_CTRL_READY(ready), .REG_ENABLE(en_o),
    .POWER_GOOD_RESET_N_O(por_o), .POWER_GOOD_RESET_N_OE(por_oe), .FAULT_IRQ_N_O(irq_o),
    .FAULT_IRQ_N_OE(irq_oe), .DDR_REF_OUTPUT_ON(ref_on), .CLK_UNTRIMMED_SEL(slow_sel),
    .SWITCH_CLK_TICK(sw_tick), .DEBOUNCE_TICK(db_tick), .IRQ_DEBOUNCE_TICK(irq_tick),
    .I2C_ADDR(i2c), .POWER_STATE(state));
  pms_host_model pms_host_model_i (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wdata), .en(en), .req(req));
  // clock and time-zero values
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    utick = 1'h0;
    tcnt = 6'h00;
    forever #50 clk = ~clk;
  end
  // untrimmed low-rate pulse, one cycle in 64
  always @(posedge clk) begin
    tcnt <= tcnt + 6'h01;
    utick <= (tcnt == 6'h3F);
  end
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // supply, thermal, pfm and fault levels, changed on a rising edge
  task automatic set_env(input logic [4:0] v);
    @(posedge clk);
    {supply, therm, pfm_any, all_pfm, fault} <= v;
  endtask : set_env
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  // cycles until enables or reset pin move
  task automatic wait_chg(output int k);
    logic [10:0] prev;
    prev = {por_oe, en_o};
    k = 0;
    while ({por_oe, en_o} === prev && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 3000) begin
      chk("enable change", 1, 0);
      summarize();
    end
  endtask : wait_chg
  task automatic wait_state(input logic [1:0] s, output int k);
    k = 0;
    while (state !== s && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (state !== s) begin
      chk("power state", s, state);
      summarize();
    end
  endtask : wait_state
  // reset values and register access in OFF
  task automatic sc_regs;
    chk("state", pms_pkg::PMS_OFF, state);
    chk("reset pin", 0, por_n);
    chk("i2c address", 7'h08, i2c);
    pms_host_model_i.read(8'h1B, rd_v);
    chk("power control", 8'h10, rd_v);
    pms_host_model_i.read(`PMS_ADDR_RAM_SEL, rd_v);
    chk("ram select", 8'h00, rd_v);
    pms_host_model_i.write(8'h6A, 8'hFF);
    pms_host_model_i.read(8'h6A, rd_v);
    chk("ddr ref reg", 8'h10, rd_v);
    chk("ddr ref on", 1, ref_on);
    pms_host_model_i.write(8'h6A, 8'h00);
    pms_host_model_i.write(8'h55, 8'hA5);
    pms_host_model_i.read(8'h55, rd_v);
    chk("unmapped", 8'h00, rd_v);
    chk("ddr ref off", 0, ref_on);
  endtask : sc_regs
  // default slots, spacing and reset release
  task automatic sc_default_seq;
    pms_host_model_i.set_en(1'h1);
    for (int i = 0; i < 4; i++) begin
      wait_chg(n);
      chk("slot time", (i == 0) ? FIRST : SLOT, n);
      chk("slot enables", DEF_EN[i], en_o);
    end
    chk("on state", pms_pkg::PMS_ON, state);
    wait_chg(n);
    chk("reset release time", PG, n);
    chk("reset released", 1, por_n);
    chk("host ready after seq", 1, ready);
  endtask : sc_default_seq
  // switching tick, irq tick, clock choice
  task automatic sc_clocks;
    n = 0;
    m = 0;
    for (int i = 0; i < 312; i++) begin
      @(posedge clk);
      #1;
      if (i < 50) n += int'(sw_tick);
      m += int'(db_tick);
    end
    chk("switch ticks", 10, n);
    chk("debounce ticks", 1, m);
    chk("trimmed clock", 0, slow_sel);
    for (int i = 0; i < 70 && utick !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    chk("irq debounce tick", 1, irq_tick);
    set_env(5'h12);
    @(posedge clk);
    #1;
    chk("untrimmed on pfm", 1, slow_sel);
    set_env(5'h10);
  endtask : sc_clocks
  task automatic sc_standby;
    pms_host_model_i.set_req(1'h1);
    wait_state(pms_pkg::PMS_STANDBY, n);
    chk("sync delay", 1, n >= 938 && n <= 1250);
    chk("mirrored enables", 10'h3FF, en_o);
    pms_host_model_i.set_req(1'h0);
    wait_state(pms_pkg::PMS_ON, n);
    pms_host_model_i.lowpower_setup(8'h40, 8'h00);
    wait_state(pms_pkg::PMS_STANDBY, n);
    chk("standby enables", 10'h3FE, en_o);
    pms_host_model_i.read(8'h1B, rd_v);
    chk("invert bit", 8'h40, rd_v);
    pms_host_model_i.set_req(1'h1);
    wait_state(pms_pkg::PMS_ON, n);
    chk("resume enables", 10'h3FF, en_o);
  endtask : sc_standby
  // sleep and back, then off, with a fault pending
  task automatic sc_sleep_off;
    set_env(5'h15);
    repeat (2) @(posedge clk);
    #1;
    chk("irq in on", 0, irq_n);
    pms_host_model_i.set_en(1'h0);
    wait_state(pms_pkg::PMS_SLEEP, n);
    chk("irq in sleep", 0, irq_n);
    pms_host_model_i.set_en(1'h1);
    wait_state(pms_pkg::PMS_ON, n);
    chk("reset kept", 1, por_n);
    set_env(5'h11);
    pms_host_model_i.set_en(1'h0);
    wait_state(pms_pkg::PMS_OFF, n);
    chk("off reset pin", 0, por_n);
    chk("off enables", 10'h000, en_o);
    chk("irq in off", 1, irq_n);
    set_env(5'h10);
  endtask : sc_sleep_off
  // retained slots, refused write, thermal and low supply
  task automatic sc_ram_seq;
    for (int i = 0; i < 9; i++) begin
      pms_host_model_i.write(8'h20 + 8'(i), (i == 0) ? 8'h00 : 8'h01);
    end
    pms_host_model_i.write(8'h29, 8'h03);
    pms_host_model_i.write(`PMS_ADDR_RAM_SEL, 8'h01);
    pms_host_model_i.set_en(1'h1);
    pms_host_model_i.write(8'h6A, 8'h10);
    wait_chg(n);
    chk("ram slot1 time", FIRST - 2, n);
    chk("ram slot1", 10'h1FE, en_o);
    chk("write dropped", 0, ref_on);
    chk("host ready in seq", 0, ready);
    wait_chg(n);
    chk("empty slot skipped", SLOT, n);
    chk("ram slot3", 10'h3FE, en_o);
    wait_chg(n);
    chk("ram reset release", PG, n);
    set_env(5'h18);
    wait_state(pms_pkg::PMS_OFF, n);
    repeat (5) @(posedge clk);
    #1;
    chk("thermal blocks on", pms_pkg::PMS_OFF, state);
    set_env(5'h00);
    repeat (5) @(posedge clk);
    #1;
    chk("low supply blocks on", pms_pkg::PMS_OFF, state);
    chk("untrimmed low supply", 1, slow_sel);
    set_env(5'h10);
    wait_state(pms_pkg::PMS_ON, n);
  endtask : sc_ram_seq
  // supply-valid reset in mid-sequence
  task automatic sc_second_reset;
    @(posedge clk);
    rst <= 1'h1;
    pms_host_model_i.set_en(1'h0);
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    chk("state after reset", pms_pkg::PMS_OFF, state);
    chk("enables after reset", 10'h000, en_o);
    chk("reset pin after reset", 0, por_n);
    pms_host_model_i.read(`PMS_ADDR_RAM_SEL, rd_v);
    chk("ram select cleared", 8'h00, rd_v);
  endtask : sc_second_reset
  // main sequence
  initial begin
    set_env(5'h10);
    repeat (9) @(posedge clk);
    rst <= 1'h0;
    sc_regs();
    sc_default_seq();
    sc_clocks();
    sc_standby();
    sc_sleep_off();
    sc_ram_seq();
    sc_second_reset();
    summarize();
  end
endmodule : pms_power_sequencer_tb

// ===== pms_regs.svh
// register offsets, field positions, reset values and timing figures of the sequencer
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH
`define PMS_NUM_REGS 10
`define PMS_SLOT_W 5
`define PMS_ADDR_PWR_CTRL 8'h1B
`define PMS_ADDR_DDR_REF 8'h6A
`define PMS_ADDR_RAM_SEL 8'h7F
`define PMS_ADDR_SLOT_BASE 8'h20
`define PMS_ADDR_LOW_POWER_REQUEST_BASE 8'h30
`define PMS_BIT_INVERT 6
`define PMS_DLY_MSB 5
`define PMS_DLY_LSB 4
`define PMS_BIT_REF_ON 4
`define PMS_BIT_RAM_SEL 0
`define PMS_RST_INVERT 1'h0
`define PMS_RST_DELAY 2'h1
`define PMS_RST_REF_ON 1'h0
`define PMS_RST_RAM_SEL 1'h0
`define PMS_I2C_ADDR 7'h08
`define PMS_CLK_PERIOD_NS 100
`define PMS_CORE_CLK_HZ 10000000
`define PMS_SW_CLK_HZ 2000000
`define PMS_LF_CLK_HZ 32000
`define PMS_SLOT_PERIOD_NS 1000000
`define PMS_FIRST_SLOT_NS 2500000
`define PMS_PGOOD_DELAY_NS 2000000
`define PMS_SYNC_STAGES 3
// default slots, regulator 9 (ddr reference) down to regulator 0 (buck 1)
`define PMS_DEF_SLOTS {5'h03, 5'h01, 5'h01, 5'h01, 5'h01, 5'h04, 5'h03, 5'h03, 5'h02, 5'h02}
`endif

// ===== pms_tick_gen.sv
// divider of the master clock into switching and low-rate enables
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_tick_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_on,
  pms_tick_if.gen tk
);
  localparam logic [9:0] SW_DIV = 10'(`PMS_CORE_CLK_HZ / `PMS_SW_CLK_HZ);
  localparam logic [9:0] LF_DIV = 10'(`PMS_CORE_CLK_HZ / `PMS_LF_CLK_HZ);
  logic [9:0] sw_cnt;
  logic [9:0] lf_cnt;
  logic sw_tick;
  logic lf_tick;
  wire sw_wrap = (sw_cnt == SW_DIV - 10'h001);
  wire lf_wrap = (lf_cnt == LF_DIV - 10'h001);
  // free counters, held at zero while the trimmed oscillator is off
  always_ff @(posedge clk) begin
    if (rst || !osc_on) begin
      sw_cnt <= 10'h000;
      lf_cnt <= 10'h000;
      sw_tick <= 1'b0;
      lf_tick <= 1'b0;
    end else begin
      sw_cnt <= sw_wrap ? 10'h000 : sw_cnt + 10'h001;
      lf_cnt <= lf_wrap ? 10'h000 : lf_cnt + 10'h001;
      sw_tick <= sw_wrap;
      lf_tick <= lf_wrap;
    end
  end
  assign tk.tick_2m = sw_tick;
  assign tk.tick_32k = lf_tick;
endmodule : pms_tick_gen

// ===== pms_tick_if.sv
// tick enables passed from the divider to the sequencer
`timescale 1ns/1ps
interface pms_tick_if;
  logic tick_2m;
  logic tick_32k;
  modport gen (output tick_2m, output tick_32k);
  modport use_side (input tick_2m, input tick_32k);
endinterface : pms_tick_if
